// *** hdl/rtcctl_top.sv ***
/*
 * Real-time clock control and status register with a small seconds
 * timebase, signed per-minute drift trim and clock output pin.
 * Assumes an APB master on clk, a power-on reset on rst_n, and
 * system reset, CPU idle and alarm pulse arriving from the same clock.
 */
//
// Function
// - Trim is signed 10 bits; each minute it adds (positive) or removes (negative) that many timebase pulses.
// - Enable bit 15 turns the clock module on when set and off when clear.
// - Writes to the enable bit take effect only while the write-unlock bit is 1.
// - Idle-stop bit 13 halts the module while the processor idles; clear keeps it running.
// - Output select bit 7 picks the seconds clock (1) or alarm pulse (0) for the pin.
// - The pin carries the selected source only while output enable bit 0 is 1.
// - Running status bit 6 reads 1 while the clock is running and 0 when stopped.
// - The write-unlock bit can be set only after the software unlock sequence has been written.
// - Half-second flag is read-only and is cleared by any write to time register bits 14:8.
// - The control register resets only on power-on reset, not on other resets.
// - Bits 31-26, 14, 12-8 and 5-4 ignore writes and read as zero.
`timescale 1ns/100ps
`include "rtcctl_params.svh"

module rtcctl_top
    import rtcctl_pkg::*;
#(
    parameter int TICK_DIV     = `RTCCTL_TICK_DIV,
    parameter int TICKS_HALF   = `RTCCTL_TICKS_PER_HALF,
    parameter int HALVES_MIN   = `RTCCTL_HALVES_PER_MIN
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sys_rst_n,
    input  wire logic        cpu_idle,
    input  wire logic        alarm_pulse,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             clk_out_pin,
    output logic             clk_out_oe,
    output logic             rtc_running
);

    logic [9:0]  trim_q;
    logic        enable_q;
    logic        idle_stop_q;
    logic        out_sel_q;
    logic        out_en_q;
    logic        unlock_q;
    logic        half_sec_q;
    logic [6:0]  seconds_q;
    logic [31:0] time_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        pin_q;
    logic        oe_q;
    logic        run_q;
    logic [15:0] div_cnt_q;
    logic [15:0] tick_cnt_q;
    logic [6:0]  half_cnt_q;
    logic [9:0]  trim_left_q;
    logic        sec_level_q;
    logic        sync_q;
    logic        trim_neg_q;
    rtcctl_key_t key_q;

    logic        setup;
    logic        wr;
    logic        rd;
    logic        hit_ctrl;
    logic        hit_time;
    logic        hit_unlock;
    logic        hit_env;
    logic        run;
    logic        tick;
    logic        half_end;
    logic        minute_end;
    logic        trim_busy;
    logic        swallow;
    logic        skip;
    logic [31:0] ctrl_rd;

    // Single-cycle answer: the slave responds in the setup phase's following access cycle
    assign setup      = psel && !penable;
    assign wr         = psel && penable && pwrite;
    assign rd         = psel && penable && !pwrite;
    assign hit_ctrl   = paddr == `RTCCTL_CTRL_OFS;
    assign hit_time   = paddr == `RTCCTL_TIME_OFS;
    assign hit_unlock = paddr == `RTCCTL_UNLOCK_OFS;
    assign hit_env    = paddr == `RTCCTL_ENV_OFS;

    // Timebase runs only while enabled and not held off by idle stop
    assign run = enable_q && !(idle_stop_q && cpu_idle);

    assign tick       = run && (div_cnt_q == 16'(TICK_DIV - 1));
    assign half_end   = tick && (tick_cnt_q == 16'(TICKS_HALF - 1));
    assign minute_end = half_end && (half_cnt_q == 7'(HALVES_MIN - 1));

    // A step of two must never jump over the last count of a half second,
    // so an extra tick that would land there waits for the next half
    assign trim_busy  = trim_left_q != 10'h000;
    assign swallow    = tick && !half_end && trim_busy && trim_neg_q;
    assign skip       = tick && !half_end && trim_busy && !trim_neg_q && (tick_cnt_q < 16'(TICKS_HALF - 2));

    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[`RTCCTL_TRIM_HI:`RTCCTL_TRIM_LO] = trim_q;
        ctrl_rd[`RTCCTL_ENABLE_BIT]    = enable_q;
        ctrl_rd[`RTCCTL_IDLE_STOP_BIT] = idle_stop_q;
        ctrl_rd[`RTCCTL_OUT_SEL_BIT]   = out_sel_q;
        ctrl_rd[`RTCCTL_RUNNING_BIT]   = run_q;
        ctrl_rd[`RTCCTL_UNLOCK_BIT]    = unlock_q;
        ctrl_rd[`RTCCTL_SYNC_BIT]      = sync_q;
        ctrl_rd[`RTCCTL_HALF_SEC_BIT]  = half_sec_q;
        ctrl_rd[`RTCCTL_OUT_EN_BIT]    = out_en_q;
    end

    // Control fields: only power-on reset clears them, system reset is ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trim_q      <= 10'h000;
            enable_q    <= 1'b0;
            idle_stop_q <= 1'b0;
            out_sel_q   <= 1'b0;
            out_en_q    <= 1'b0;
        end else if (wr && hit_ctrl) begin
            trim_q      <= pwdata[`RTCCTL_TRIM_HI:`RTCCTL_TRIM_LO];
            idle_stop_q <= pwdata[`RTCCTL_IDLE_STOP_BIT];
            out_sel_q   <= pwdata[`RTCCTL_OUT_SEL_BIT];
            out_en_q    <= pwdata[`RTCCTL_OUT_EN_BIT];
            if (unlock_q) begin
                enable_q <= pwdata[`RTCCTL_ENABLE_BIT];
            end
        end
    end

    // Unlock sequence: two key words back to back on the unlock address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_q <= RTCCTL_KEY_IDLE;
        end else if (wr && hit_unlock) begin
            case (key_q)
                RTCCTL_KEY_IDLE:  key_q <= (pwdata == `RTCCTL_KEY1) ? RTCCTL_KEY_FIRST : RTCCTL_KEY_IDLE;
                RTCCTL_KEY_FIRST: key_q <= (pwdata == `RTCCTL_KEY2) ? RTCCTL_KEY_OPEN : RTCCTL_KEY_IDLE;
                RTCCTL_KEY_OPEN:  key_q <= RTCCTL_KEY_OPEN;
                default:          key_q <= RTCCTL_KEY_IDLE;
            endcase
        end else if (wr) begin
            // Any other write closes the sequence so a stray pair cannot linger
            key_q <= RTCCTL_KEY_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unlock_q <= 1'b0;
        end else if (wr && hit_ctrl) begin
            if (!pwdata[`RTCCTL_UNLOCK_BIT]) begin
                unlock_q <= 1'b0;
            end else if (key_q == RTCCTL_KEY_OPEN) begin
                unlock_q <= 1'b1;
            end
        end
    end

    // Time register: seconds field kept in bits 14:8, rest is plain storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            time_q <= 32'h0000_0000;
        end else if (wr && hit_time) begin
            time_q <= pwdata;
        end
    end

    // Seconds advance at the end of the second half of each second;
    // the bit above the field is held in time_q but never read back, so it reads as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seconds_q <= 7'h00;
        end else if (wr && hit_time) begin
            seconds_q <= pwdata[`RTCCTL_TIME_SEC_HI:`RTCCTL_TIME_SEC_LO];
        end else if (half_end && half_sec_q) begin
            seconds_q <= (seconds_q == 7'h3B) ? 7'h00 : seconds_q + 7'h01;
        end
    end

    // Set on a half-second boundary, cleared by a seconds write; the write wins
    // since software explicitly realigns the second at that moment
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_sec_q <= 1'b0;
        end else if (wr && hit_time) begin
            half_sec_q <= 1'b0;
        end else if (half_end) begin
            half_sec_q <= !half_sec_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_q <= 16'h0000;
        end else if (run) begin
            div_cnt_q <= tick ? 16'h0000 : div_cnt_q + 16'h0001;
        end
    end

    // Trim: positive values add extra ticks, negative values swallow ticks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0000;
        end else if ((wr && hit_time) || half_end) begin
            tick_cnt_q <= 16'h0000;
        end else if (skip) begin
            tick_cnt_q <= tick_cnt_q + 16'h0002;
        end else if (tick && !swallow) begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_cnt_q <= 7'h00;
        end else if (minute_end) begin
            half_cnt_q <= 7'h00;
        end else if (half_end) begin
            half_cnt_q <= half_cnt_q + 7'h01;
        end
    end

    // The sign is latched with the count, so rewriting the trim field in mid
    // minute cannot turn a pending correction around; a new value applies
    // from the next minute on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trim_left_q <= 10'h000;
            trim_neg_q  <= 1'b0;
        end else if (minute_end) begin
            trim_left_q <= trim_q[9] ? 10'(-trim_q) : trim_q;
            trim_neg_q  <= trim_q[9];
        end else if (swallow || skip) begin
            trim_left_q <= trim_left_q - 10'h001;
        end
    end

    // Seconds clock level: high in the first half of each second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sec_level_q <= 1'b0;
        end else begin
            sec_level_q <= !half_sec_q;
        end
    end

    // Sync flag warns that a rollover is close, so software can avoid a torn read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= run && half_sec_q && (tick_cnt_q > 16'(TICKS_HALF - `RTCCTL_SYNC_WINDOW));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= out_en_q && (out_sel_q ? sec_level_q : alarm_pulse);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= out_en_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run;
        end
    end

    // Zero wait states: the answer is registered from the setup cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    // Unmapped offsets answer with an error; a write there changes no register except the unlock sequence, which returns to idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup && !(hit_ctrl || hit_time || hit_unlock || hit_env);
        end
    end

    // Writes answer with zero so no stale read word travels with them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            if (pwrite) begin
                prdata_q <= 32'h0000_0000;
            end else if (hit_ctrl) begin
                prdata_q <= ctrl_rd;
            end else if (hit_time) begin
                prdata_q <= {time_q[31:16], 1'b0, seconds_q, time_q[7:0]};
            end else if (hit_env) begin
                prdata_q <= {30'h0000_0000, !sys_rst_n, cpu_idle};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign clk_out_pin = pin_q;
    assign clk_out_oe  = oe_q;
    assign rtc_running = run_q;

endmodule : rtcctl_top

// *** common/rtcctl_params.svh ***
/*
 * Register offsets, field positions, unlock keys and timing counts
 * for the real-time clock control block. Definitions only.
 */
`ifndef RTCCTL_PARAMS_SVH
`define RTCCTL_PARAMS_SVH

`define RTCCTL_CTRL_OFS         12'h000
`define RTCCTL_TIME_OFS         12'h004
`define RTCCTL_UNLOCK_OFS       12'h008
`define RTCCTL_ENV_OFS          12'h00C
`define RTCCTL_TRIM_HI          25
`define RTCCTL_TRIM_LO          16
`define RTCCTL_ENABLE_BIT       15
`define RTCCTL_IDLE_STOP_BIT    13
`define RTCCTL_OUT_SEL_BIT      7
`define RTCCTL_RUNNING_BIT      6
`define RTCCTL_UNLOCK_BIT       3
`define RTCCTL_SYNC_BIT         2
`define RTCCTL_HALF_SEC_BIT     1
`define RTCCTL_OUT_EN_BIT       0
`define RTCCTL_CTRL_WMASK       32'h03FF_208D
`define RTCCTL_TIME_SEC_HI      14
`define RTCCTL_TIME_SEC_LO      8
`define RTCCTL_KEY1             32'h0000_AA99
`define RTCCTL_KEY2             32'h0000_5566
`define RTCCTL_TICK_HZ          32768
`define RTCCTL_CLK_HZ           250000000
`define RTCCTL_TICK_DIV         (`RTCCTL_CLK_HZ / `RTCCTL_TICK_HZ)
`define RTCCTL_TICKS_PER_HALF   (`RTCCTL_TICK_HZ / 2)
`define RTCCTL_HALVES_PER_MIN   120
`define RTCCTL_SYNC_WINDOW      32

`endif

// *** common/rtcctl_pkg.sv ***
/*
 * Types for the real-time clock control block.
 * Assumes rtcctl_params.svh for all numeric constants.
 */
package rtcctl_pkg;
    typedef enum logic [1:0] {
        RTCCTL_KEY_IDLE,
        RTCCTL_KEY_FIRST,
        RTCCTL_KEY_OPEN
    } rtcctl_key_t;
endpackage : rtcctl_pkg

// *** verif/rtcctl_checker.sv ***
/* Port assertions for rtcctl_top.
   Assumes zero-wait APB on clk and rst_n as the synchronous reset. */
`timescale 1ns/100ps
`include "rtcctl_params.svh"
module rtcctl_checker #(parameter int TICK_DIV = 4, TICKS_HALF = 8, HALVES_MIN = 4) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sys_rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        clk_out_pin,
    input wire logic        clk_out_oe,
    input wire logic        rtc_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd_c;
    logic bad_a;
    assign rd_c  = pready && psel && !pwrite && paddr == `RTCCTL_CTRL_OFS;
    assign bad_a = paddr > `RTCCTL_ENV_OFS || paddr[1:0] != 2'h0;
    property p_zero_wait; psel && !penable |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_rsvd_zero; rd_c |-> (prdata & 32'hFC00_5F30) == 32'h0; endproperty
    property p_pin_gate; clk_out_pin |-> clk_out_oe; endproperty
    property p_run_read;
        rd_c && rtc_running && $past(rtc_running) && $past(rtc_running, 2) |-> prdata[6];
    endproperty
    property p_unmapped; psel && !penable && bad_a |=> pslverr && pready && prdata == 32'h0; endproperty
    property p_mapped_ok; psel && !penable && !bad_a |=> !pslverr; endproperty
    property p_sysrst_hold;
        !sys_rst_n && !psel && !$past(psel) && !$past(psel, 2) |=> $stable(clk_out_oe);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");
    a_run_read: assert property (p_run_read) else $error("running bit low");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped refused");
    a_sysrst_hold: assert property (p_sysrst_hold) else $error("system reset changed oe");
    c_unmapped: cover property (p_unmapped);
    c_pin: cover property (clk_out_pin);
    c_run: cover property (rd_c && rtc_running);
endmodule : rtcctl_checker

bind rtcctl_top rtcctl_checker #(.TICK_DIV(TICK_DIV), .TICKS_HALF(TICKS_HALF), .HALVES_MIN(HALVES_MIN)) u_chk (
    .clk(clk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_out_pin(clk_out_pin),
    .clk_out_oe(clk_out_oe), .rtc_running(rtc_running));

// *** verif/rtcctl_top_bench.sv ***
/* Self-checking bench for rtcctl_top.
   Assumes short timebase counts so a half second is 32 cycles. */
`timescale 1ns/100ps
`include "rtcctl_params.svh"
module rtcctl_top_bench;
    logic        clk, rst_n, sys_rst_n, cpu_idle, alarm_pulse, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, clk_out_pin, clk_out_oe, rtc_running, err;
    int          error_cnt = 0;
    int          checks_done = 0;
    localparam logic [31:0] M = 32'hFFFF_FFF9;
    rtcctl_top #(.TICK_DIV(4), .TICKS_HALF(8), .HALVES_MIN(4)) dut (
        .clk(clk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .cpu_idle(cpu_idle), .alarm_pulse(alarm_pulse),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_out_pin(clk_out_pin), .clk_out_oe(clk_out_oe),
        .rtc_running(rtc_running));
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One idle edge first so back-to-back calls never drive a signal twice per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, `RTCCTL_CTRL_OFS, 32'h0);
        chk(rd & m, exp);
    endtask : rdc
    task automatic t_pins(input logic [2:0] exp);
        repeat (3) @(posedge clk);
        chk({29'h0, clk_out_pin, clk_out_oe, rtc_running}, {29'h0, exp});
    endtask : t_pins
    task automatic t_lock_unlock();
        rdc(32'h0, 32'hFFFF_FFFF);
        t_pins(3'b000);
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'hFFFF_FFFF);
        rdc(32'h03FF_2081, M);
        t_pins(3'b110);
        apb(1'b1, `RTCCTL_UNLOCK_OFS, `RTCCTL_KEY1);
        apb(1'b1, `RTCCTL_UNLOCK_OFS, `RTCCTL_KEY2);
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'h03FF_2089);
        rdc(32'h03FF_2089, M);
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'h03FF_A089);
        t_pins(3'b111);
        rdc(32'h03FF_A0C9, M);
    endtask : t_lock_unlock
    task automatic t_idle_pin();
        cpu_idle <= 1'b1;
        t_pins(3'b110);
        rdc(32'h03FF_A089, M);
        cpu_idle <= 1'b0;
        t_pins(3'b111);
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'h03FF_8009);
        alarm_pulse <= 1'b1;
        t_pins(3'b111);
        alarm_pulse <= 1'b0;
        t_pins(3'b011);
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'h03FF_8008);
        alarm_pulse <= 1'b1;
        t_pins(3'b001);
        alarm_pulse <= 1'b0;
    endtask : t_idle_pin
    task automatic t_half_sysrst();
        for (int i = 0; i < 40 && rd[1] !== 1'b1; i++)
            apb(1'b0, `RTCCTL_CTRL_OFS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        apb(1'b1, `RTCCTL_TIME_OFS, 32'hFFFF_BAFF);
        rdc(32'h0, 32'h2);
        apb(1'b0, `RTCCTL_TIME_OFS, 32'h0);
        chk(rd, 32'hFFFF_3AFF);
        sys_rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, `RTCCTL_ENV_OFS, 32'h0);
        chk(rd, 32'h0000_0002);
        sys_rst_n <= 1'b1;
        rdc(32'h03FF_8048, M);
    endtask : t_half_sysrst
    task automatic t_off_unmapped();
        apb(1'b1, `RTCCTL_CTRL_OFS, 32'h03FF_0088);
        t_pins(3'b000);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        rdc(32'h03FF_0088, M);
    endtask : t_off_unmapped
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Generous bound: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {rst_n, cpu_idle, alarm_pulse, psel, penable, pwrite} = 6'h0;
        sys_rst_n = 1'b1;
        paddr     = 12'h0;
        pwdata    = 32'h0;
        rd        = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_lock_unlock();
        t_idle_pin();
        t_half_sysrst();
        t_off_unmapped();
        print_verdict();
    end
endmodule : rtcctl_top_bench
